// ### verilog/lws_pkg.sv
// Package of the listen mode wake sequencer: register map, field codes,
// state encoding and carrier structs.
// Assumes a 32-bit APB slave with word-aligned registers.
package lws_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] LWS_OFF_CTRL    = 8'h00;  // Sequencer control
  localparam logic [7:0] LWS_OFF_CONFIG  = 8'h04;  // Transition selects
  localparam logic [7:0] LWS_OFF_SLEEP_T = 8'h08;  // Sleep interval count
  localparam logic [7:0] LWS_OFF_RXWIN_T = 8'h0C;  // Receive window count
  localparam logic [7:0] LWS_OFF_STATUS  = 8'h10;  // Sticky events, rd clr
  localparam logic [7:0] LWS_OFF_MASK    = 8'h14;  // Interrupt mask
  localparam logic [7:0] LWS_OFF_STATE   = 8'h18;  // Current state, ro

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int LWS_CTRL_START   = 0;  // Write 1: start sequencer
  localparam int LWS_CTRL_STOP    = 1;  // Write 1: stop, go standby
  localparam int LWS_CFG_IDLE     = 0;  // idle_low_power_select
  localparam int LWS_CFG_START_LO = 1;  // start_transition_select [2:1]
  localparam int LWS_CFG_LOWP     = 3;  // low_power_target_select
  localparam int LWS_CFG_IDLEX    = 4;  // idle_exit_select
  localparam int LWS_CFG_RXX_LO   = 5;  // receive_exit_select [7:5]
  localparam int LWS_CFG_MAP_EN   = 8;  // preamble_event_map_enable
  localparam int LWS_CFG_G4_LO    = 9;  // general_output_four map [10:9]
  localparam int LWS_ST_PREAMBLE  = 0;  // Preamble found event
  localparam int LWS_ST_WIN_END   = 1;  // Window ended, no preamble stop
  localparam int LWS_ST_PACKET    = 2;  // Packet received while listening
  localparam int LWS_EV_W         = 3;  // Number of event bits

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] LWS_RXX_PREAMBLE = 3'h6;  // Exit on preamble
  localparam logic [1:0] LWS_G4_PREAMBLE  = 2'h3;  // Pin map to preamble
  localparam logic [1:0] LWS_START_LOWP   = 2'h0;  // Start to low power
  localparam logic [10:0] LWS_CFG_RST     = 11'h000;
  localparam logic [31:0] LWS_SLEEP_RST   = 32'h0000_0400;
  localparam logic [31:0] LWS_RXWIN_RST   = 32'h0000_0040;

  // ---------------------------------------------------------------
  // State encoding, Gray along idle -> receive -> off
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LWS_ST_STANDBY = 3'h0,  // Sequencer off, radio standby
    LWS_ST_IDLE    = 3'h1,  // Low power, sleep interval running
    LWS_ST_RX      = 3'h3,  // Receive window running
    LWS_ST_RX_HOLD = 3'h2,  // Sequencer off, radio kept in receive
    LWS_ST_LOWSTBY = 3'h6   // Low power standby idle variant
  } lws_state_t;

  // Events from the radio, already synchronised
  typedef struct packed {
    logic packet;    // Packet received
    logic preamble;  // Preamble detected
  } lws_radio_ev_t;

  // Radio mode requests to the analog side
  typedef struct packed {
    logic rx_on;     // Receiver enabled
    logic sleep;     // Sleep, only RC oscillator running
  } lws_radio_ctl_t;

endpackage

// ### verilog/lws_timer.sv
// Down counter shared for the sleep interval and receive window timers.
// Assumes load and the count value come from logic on pclk.
`timescale 1ns/100ps
module lws_timer
  import lws_pkg::*;
#(
  parameter int W = 32  // Counter width
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         run,
  output logic              expired
);

  logic [W-1:0] cnt_r;    // Remaining cycles
  logic [W-1:0] cnt_nxt;  // Next count
  logic         exp_r;    // One-cycle expiry pulse
  logic         exp_nxt;  // Next expiry

  // Load wins; a zero count loads as one, never stalls
  always_comb
  begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (load)
    begin
      cnt_nxt = (value == '0) ? W'(1) : value;
    end
    else if (run && cnt_r != '0)
    begin
      cnt_nxt = cnt_r - W'(1);
      exp_nxt = (cnt_r == W'(1));
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;

endmodule // lws_timer

// ### verilog/lws_top.sv
// Listen mode wake sequencer: alternates low power idle and receive
// windows, stops on preamble, alerts the host by pin and interrupt.
// Assumes radio event inputs are asynchronous pins; APB on pclk.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps

module lws_top
  import lws_pkg::*;
#(
  parameter int TW = 32  // Timer width
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        preamble_pin,
  input  wire logic        packet_pin,
  output lws_radio_ctl_t   radio_ctl,
  output logic             general_output_four,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] s1_r;         // First stage, read only by s2_r
  logic [1:0] s2_r;         // Second stage
  lws_radio_ev_t ev;        // Synchronised events

  // Two flops per pin; the events are levels from the modem
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_r <= 2'h0;
      s2_r <= 2'h0;
    end
    else
    begin
      s1_r <= {packet_pin, preamble_pin};
      s2_r <= s1_r;
    end
  end

  assign ev.preamble = s2_r[0];
  assign ev.packet   = s2_r[1];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic        wr_en;       // Write access phase
  logic        rd_en;       // Read access phase
  logic        mapped;      // Address is a register
  logic [31:0] rd_data;     // Read mux

  // Zero wait state slave: every access ends in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign mapped = (paddr == LWS_OFF_CTRL)    || (paddr == LWS_OFF_CONFIG) ||
                  (paddr == LWS_OFF_SLEEP_T) || (paddr == LWS_OFF_RXWIN_T) ||
                  (paddr == LWS_OFF_STATUS)  || (paddr == LWS_OFF_MASK) ||
                  (paddr == LWS_OFF_STATE);
  // Unmapped addresses answer with an error and read zero
  assign pslverr = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [10:0]   cfg_r;     // Transition selects and pin map
  logic [10:0]   cfg_nxt;
  logic [TW-1:0] sleep_r;   // Sleep interval in cycles
  logic [TW-1:0] sleep_nxt;
  logic [TW-1:0] rxwin_r;   // Receive window in cycles
  logic [TW-1:0] rxwin_nxt;
  logic [LWS_EV_W-1:0] mask_r;    // Interrupt enables
  logic [LWS_EV_W-1:0] mask_nxt;
  logic          start_wr;  // Start strobe
  logic          stop_wr;   // Stop strobe, a new mode from the host

  // Config writes
  always_comb
  begin
    cfg_nxt   = cfg_r;
    sleep_nxt = sleep_r;
    rxwin_nxt = rxwin_r;
    mask_nxt  = mask_r;
    if (wr_en && paddr == LWS_OFF_CONFIG)
    begin
      cfg_nxt = pwdata[10:0];
    end
    if (wr_en && paddr == LWS_OFF_SLEEP_T)
    begin
      sleep_nxt = pwdata[TW-1:0];
    end
    if (wr_en && paddr == LWS_OFF_RXWIN_T)
    begin
      rxwin_nxt = pwdata[TW-1:0];
    end
    if (wr_en && paddr == LWS_OFF_MASK)
    begin
      mask_nxt = pwdata[LWS_EV_W-1:0];
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r   <= LWS_CFG_RST;
      sleep_r <= LWS_SLEEP_RST[TW-1:0];
      rxwin_r <= LWS_RXWIN_RST[TW-1:0];
      mask_r  <= '0;
    end
    else
    begin
      cfg_r   <= cfg_nxt;
      sleep_r <= sleep_nxt;
      rxwin_r <= rxwin_nxt;
      mask_r  <= mask_nxt;
    end
  end

  assign start_wr = wr_en && paddr == LWS_OFF_CTRL && pwdata[LWS_CTRL_START];
  assign stop_wr  = wr_en && paddr == LWS_OFF_CTRL && pwdata[LWS_CTRL_STOP];

  // ---------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------
  lws_state_t state_r;      // Current state
  lws_state_t state_nxt;
  logic       t1_load;      // Load sleep timer
  logic       t2_load;      // Load window timer
  logic       t1_exp;       // Sleep interval over
  logic       t2_exp;       // Window over
  logic       pre_stop;     // Preamble ends the window
  logic       win_empty;    // Window ended without a preamble stop
  logic       lowp_state;   // In one of the idle states

  assign lowp_state = (state_r == LWS_ST_IDLE) ||
                      (state_r == LWS_ST_LOWSTBY);
  assign pre_stop = (state_r == LWS_ST_RX) && ev.preamble &&
                    (cfg_r[LWS_CFG_RXX_LO+:3] == LWS_RXX_PREAMBLE);
  assign win_empty = (state_r == LWS_ST_RX) && t2_exp && !pre_stop;

  // Next state; stop from the host wins over every transition
  always_comb
  begin
    state_nxt = state_r;
    t1_load   = 1'b0;
    t2_load   = 1'b0;
    case (state_r)
      LWS_ST_STANDBY:
      begin
        if (start_wr && !stop_wr)
        begin
          state_nxt = cfg_r[LWS_CFG_IDLE] ? LWS_ST_IDLE : LWS_ST_LOWSTBY;
          t1_load   = 1'b1;
        end
      end
      LWS_ST_IDLE, LWS_ST_LOWSTBY:
      begin
        if (t1_exp && cfg_r[LWS_CFG_IDLEX])
        begin
          state_nxt = LWS_ST_RX;
          t2_load   = 1'b1;
        end
        else if (t1_exp)
        begin
          // No receive transition selected: keep cycling the period
          t1_load = 1'b1;
        end
      end
      LWS_ST_RX:
      begin
        if (pre_stop)
        begin
          state_nxt = LWS_ST_RX_HOLD;
        end
        else if (t2_exp)
        begin
          state_nxt = cfg_r[LWS_CFG_IDLE] ? LWS_ST_IDLE : LWS_ST_LOWSTBY;
          t1_load   = 1'b1;
        end
      end
      LWS_ST_RX_HOLD:
      begin
        // Stays until the host writes a new mode
        state_nxt = LWS_ST_RX_HOLD;
      end
      default:
      begin
        state_nxt = LWS_ST_STANDBY;
      end
    endcase
    if (stop_wr)
    begin
      state_nxt = LWS_ST_STANDBY;
      t1_load   = 1'b0;
      t2_load   = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= LWS_ST_STANDBY;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  // Sleep interval runs only in idle, so the period is sleep + window
  lws_timer #(.W(TW)) u_sleep_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (t1_load),
    .value   (sleep_r),
    .run     (lowp_state),
    .expired (t1_exp)
  );

  lws_timer #(.W(TW)) u_rxwin_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (t2_load),
    .value   (rxwin_r),
    .run     (state_r == LWS_ST_RX),
    .expired (t2_exp)
  );

  // ---------------------------------------------------------------
  // Radio control, pin map, events and interrupt
  // ---------------------------------------------------------------
  lws_radio_ctl_t ctl_r;    // Registered radio request
  lws_radio_ctl_t ctl_nxt;
  logic           g4_r;     // Registered output pin
  logic           g4_nxt;
  logic [LWS_EV_W-1:0] stat_r;    // Sticky events
  logic [LWS_EV_W-1:0] stat_nxt;
  logic [LWS_EV_W-1:0] ev_set;    // Events this cycle
  logic           st_rd;    // Status read clears it

  assign st_rd = rd_en && paddr == LWS_OFF_STATUS;

  // Radio follows state next value so request and state agree
  always_comb
  begin
    ctl_nxt.rx_on = (state_nxt == LWS_ST_RX) ||
                    (state_nxt == LWS_ST_RX_HOLD);
    ctl_nxt.sleep = (state_nxt == LWS_ST_IDLE);
    g4_nxt = cfg_r[LWS_CFG_MAP_EN] &&
             (cfg_r[LWS_CFG_G4_LO+:2] == LWS_G4_PREAMBLE) && ev.preamble;
    ev_set = '0;
    ev_set[LWS_ST_PREAMBLE] = pre_stop;
    ev_set[LWS_ST_WIN_END]  = win_empty;
    ev_set[LWS_ST_PACKET]   = ev.packet && (state_r != LWS_ST_STANDBY);
    // Read clears, but an event in the same cycle survives
    stat_nxt = (st_rd ? '0 : stat_r) | ev_set;
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r  <= '0;
      g4_r   <= 1'b0;
      stat_r <= '0;
    end
    else
    begin
      ctl_r  <= ctl_nxt;
      g4_r   <= g4_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign radio_ctl           = ctl_r;
  assign general_output_four = g4_r;
  assign irq = |(stat_r & mask_r);

  // Read mux; reserved bits read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (paddr)
      LWS_OFF_CONFIG:  rd_data[10:0]          = cfg_r;
      LWS_OFF_SLEEP_T: rd_data[TW-1:0]        = sleep_r;
      LWS_OFF_RXWIN_T: rd_data[TW-1:0]        = rxwin_r;
      LWS_OFF_STATUS:  rd_data[LWS_EV_W-1:0]  = stat_r;
      LWS_OFF_MASK:    rd_data[LWS_EV_W-1:0]  = mask_r;
      LWS_OFF_STATE:   rd_data[2:0]           = state_r;
      default:         rd_data                = 32'h0000_0000;
    endcase
  end

  // Combinational read data, valid in the access phase
  assign prdata = rd_en ? rd_data : 32'h0000_0000;

endmodule // lws_top

// ### test/lws_top_monitor.sv
// Port checker of the listen mode wake sequencer.
// Assumes bench timer counts of about eight cycles.
`timescale 1ns/100ps
module lws_top_monitor
  import lws_pkg::*;
#(
  parameter int TW     = 32,  // Timer width, unused
  parameter int MAX_RX = 16,  // Longest empty window
  parameter int MAX_SL = 20   // Longest sleep run
)(
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic           preamble_pin,
  input wire logic           packet_pin,
  input wire lws_radio_ctl_t radio_ctl,
  input wire logic           general_output_four,
  input wire logic           irq
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [7:0] rx_cnt_r;  // Receive cycles, no preamble
  logic [7:0] sl_cnt_r;  // Sleep cycles in a row
  logic       pre_r;     // Preamble seen in this stay
  logic       acc;       // Write access ending
  logic       idle_sel_r; // Copy of idle_low_power_select from the bus
  assign acc = psel && penable && pwrite;

  // Counters clear while their radio request is low; the receive count also once a preamble is seen
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_cnt_r <= 8'h00;
      sl_cnt_r <= 8'h00;
      pre_r    <= 1'b0;
      idle_sel_r <= LWS_CFG_RST[LWS_CFG_IDLE];
    end
    else
    begin
      pre_r    <= radio_ctl.rx_on && (pre_r || preamble_pin);
      rx_cnt_r <= (radio_ctl.rx_on && !pre_r) ? rx_cnt_r + 8'h01 : 8'h00;
      sl_cnt_r <= radio_ctl.sleep ? sl_cnt_r + 8'h01 : 8'h00;
      // Which idle flavour the sequencer goes back to; seen on the bus
      if (acc && pready && paddr == LWS_OFF_CONFIG)
        idle_sel_r <= pwdata[LWS_CFG_IDLE];
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_excl; radio_ctl.sleep |-> !radio_ctl.rx_on; endproperty
  property p_wake;
    $rose(radio_ctl.rx_on) |-> $past(radio_ctl.sleep) == idle_sel_r;
  endproperty
  property p_back; $fell(radio_ctl.rx_on) && !$past(acc) && !$past(acc, 2)
    |-> radio_ctl.sleep == idle_sel_r; endproperty
  property p_win; rx_cnt_r <= MAX_RX; endproperty
  property p_slp; sl_cnt_r <= MAX_SL; endproperty
  property p_map; general_output_four |-> $past(preamble_pin, 3); endproperty
  property p_irq; irq && !psel |=> irq; endproperty
  property p_rd; !(psel && penable) |-> prdata == 32'h0000_0000; endproperty
  property p_rdy; psel && penable |-> pready; endproperty

  a_excl: assert property (p_excl)
    else $error("sleep and receive together");
  a_wake: assert property (p_wake)
    else $error("receive entered not from sleep");
  a_back: assert property (p_back)
    else $error("empty window did not return to sleep");
  a_win: assert property (p_win)
    else $error("receive stay too long");
  a_slp: assert property (p_slp)
    else $error("sleep interval too long");
  a_map: assert property (p_map)
    else $error("output four high without preamble");
  a_irq: assert property (p_irq)
    else $error("interrupt dropped without access");
  a_rd: assert property (p_rd)
    else $error("read data outside access");
  a_rdy: assert property (p_rdy)
    else $error("ready low in access");

  c_win: cover property ($fell(radio_ctl.rx_on));
  c_map: cover property (general_output_four);
  c_irq: cover property ($rose(irq));
endmodule // lws_top_monitor

bind lws_top lws_top_monitor #(.TW(TW)) lws_top_monitor_i (.*);

// ### test/lws_radio_model.sv
// Modem side model: reports preamble and packet to the sequencer.
// Assumes the bench commands what the far transmitter sends.
`timescale 1ns/100ps
module lws_radio_model
  import lws_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire lws_radio_ctl_t radio_ctl,
  input  wire logic           send_pre,
  input  wire logic           send_pkt,
  output logic                preamble_pin,
  output logic                packet_pin
);
  // Only a running receiver can hear the air
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      preamble_pin <= 1'b0;
      packet_pin   <= 1'b0;
    end
    else
    begin
      preamble_pin <= send_pre && radio_ctl.rx_on;
      packet_pin   <= send_pkt && radio_ctl.rx_on;
    end
endmodule // lws_radio_model

// ### test/tb_top.sv
// Testbench of the wake sequencer: APB tasks and listen scenarios.
// Assumes the modem model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top
  import lws_pkg::*;
;
  logic           pclk, presetn, psel, penable, pwrite;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, q;
  logic           pready, pslverr, e, gof, irq;
  logic           preamble_pin, packet_pin, send_pre, send_pkt;
  lws_radio_ctl_t radio_ctl;
  int             mismatches, samples_checked, n, per;

  lws_top lws_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .preamble_pin(preamble_pin), .packet_pin(packet_pin),
    .radio_ctl(radio_ctl), .general_output_four(gof), .irq(irq));
  lws_radio_model lws_radio_model_i (.pclk(pclk), .presetn(presetn),
    .radio_ctl(radio_ctl), .send_pre(send_pre), .send_pkt(send_pkt),
    .preamble_pin(preamble_pin), .packet_pin(packet_pin));

  // ----------------------------------------
  // Clock and tasks
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      mismatches++;
      conclude();
    end
  endtask

  // Count cycles until the receiver reaches a level
  task automatic wait_rx(input logic lvl);
    n = 0;
    while (radio_ctl.rx_on !== lvl)
    begin
      @(posedge pclk);
      n++;
      if (n > 300)
      begin
        mismatches++;
        conclude();
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, send_pre, send_pkt} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    apb(1'b0, LWS_OFF_CONFIG, 32'h0);
    `CHK("config", {21'h0, LWS_CFG_RST}, q)
    apb(1'b0, LWS_OFF_SLEEP_T, 32'h0);
    `CHK("sleep_t", LWS_SLEEP_RST, q)
    apb(1'b0, LWS_OFF_RXWIN_T, 32'h0);
    `CHK("rxwin_t", LWS_RXWIN_RST, q)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, e)
    // Short timers keep the run brief; exit code 110 on preamble
    apb(1'b1, LWS_OFF_SLEEP_T, 32'h8);
    // host sleep choice kept
    // Held short only so the run stays brief; a real host picks it long
    apb(1'b0, LWS_OFF_SLEEP_T, 32'h0);
    `CHK("sleep_rb", 32'h0000_0008, q)
    apb(1'b1, LWS_OFF_RXWIN_T, 32'h8);
    apb(1'b1, LWS_OFF_MASK, 32'h7);
    apb(1'b1, LWS_OFF_CONFIG, 32'h7D1);
    apb(1'b1, LWS_OFF_CTRL, 32'h1);
    wait_rx(1'b1);
    wait_rx(1'b0);
    per = n;
    `CHK("win", 1'b1, n >= 8 && n <= 10)
    `CHK("sleep", 1'b1, radio_ctl.sleep)
    wait_rx(1'b1);
    per = per + n;
    `CHK("period", 1'b1, per >= 16 && per <= 26)
    `CHK("irq_win", 1'b1, irq)
    apb(1'b0, LWS_OFF_STATUS, 32'h0);
    `CHK("st_win", 1'b1, q[LWS_ST_WIN_END])
    // Preamble sent from sleep, caught in the next window
    wait_rx(1'b0);
    send_pre <= 1'b1;
    wait_rx(1'b1);
    repeat (12) @(posedge pclk);
    `CHK("out_four", 1'b1, gof)
    apb(1'b0, LWS_OFF_STATE, 32'h0);
    `CHK("hold", LWS_ST_RX_HOLD, q[2:0])
    send_pre <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK("rx_kept", 1'b1, radio_ctl.rx_on)
    apb(1'b0, LWS_OFF_STATUS, 32'h0);
    `CHK("st_pre", 1'b1, q[LWS_ST_PREAMBLE])
    // Packet event: masked, then unmasked, then cleared
    apb(1'b1, LWS_OFF_MASK, 32'h0);
    send_pkt <= 1'b1;
    @(posedge pclk);
    send_pkt <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, LWS_OFF_MASK, 32'h4);
    @(posedge pclk);
    `CHK("irq_pkt", 1'b1, irq)
    apb(1'b0, LWS_OFF_STATUS, 32'h0);
    `CHK("st_pkt", 1'b1, q[LWS_ST_PACKET])
    @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    // Host writes a new mode after the shutdown
    apb(1'b1, LWS_OFF_CTRL, 32'h2);
    repeat (3) @(posedge pclk);
    apb(1'b0, LWS_OFF_STATE, 32'h0);
    `CHK("standby", LWS_ST_STANDBY, q[2:0])
    `CHK("rx_off", 1'b0, radio_ctl.rx_on)
    // Idle without sleep, no stop on preamble, pin map off
    apb(1'b1, LWS_OFF_CONFIG, 32'h0000_0010);
    apb(1'b1, LWS_OFF_CTRL, 32'h1);
    send_pre <= 1'b1;
    apb(1'b0, LWS_OFF_STATE, 32'h0);
    `CHK("lowstby", LWS_ST_LOWSTBY, q[2:0])
    wait_rx(1'b1);
    wait_rx(1'b0);
    `CHK("win_pre", 1'b1, n >= 8 && n <= 10)
    `CHK("no_sleep", 1'b0, radio_ctl.sleep)
    `CHK("four_off", 1'b0, gof)
    send_pre <= 1'b0;
    apb(1'b0, LWS_OFF_STATUS, 32'h0);
    `CHK("st_nopre", 2'h2, q[1:0])
    // No receive transition selected: the sleep timer only reloads
    apb(1'b1, LWS_OFF_CTRL, 32'h2);
    apb(1'b1, LWS_OFF_CONFIG, 32'h0000_0000);
    apb(1'b1, LWS_OFF_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    `CHK("no_rx", 1'b0, radio_ctl.rx_on)
    apb(1'b0, LWS_OFF_STATE, 32'h0);
    `CHK("reload", LWS_ST_LOWSTBY, q[2:0])
    apb(1'b1, LWS_OFF_CTRL, 32'h2);
    conclude();
  end
endmodule // tb_top
